//--- rtl/arf_params.svh
`ifndef ARF_PARAMS_SVH
`define ARF_PARAMS_SVH
// register addresses: format and lane registers in bank 1, bank select answers in every bank
`define ARF_ADDR_FMT_AVG      8'h0D
`define ARF_ADDR_LANE_CFG     8'h12
`define ARF_ADDR_BANK_SEL     8'h03
// bank selector code for bank 1
`define ARF_BANK1_CODE        8'h02
// reset values
`define ARF_FMT_AVG_RESET     16'h2002
`define ARF_LANE_CFG_RESET    16'h0002
`define ARF_BANK_SEL_RESET    8'h00
// field positions in the format/averaging register
`define ARF_BIT_FORMAT        13
`define ARF_BIT_GAIN_CAL      7
`define ARF_BIT_AVG_EN        6
`define ARF_DEPTH_MSB         5
`define ARF_DEPTH_LSB         2
// bits of the lane register that are writable
`define ARF_LANE_CFG_MASK     16'h000F
`endif

//--- rtl/arf_pkg.sv
package arf_pkg;
  typedef struct packed {
    logic        format_twos;
    logic        gain_cal_global_enable;
    logic        averaging_enable;
    logic [3:0]  averaging_depth;
  } arf_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [17:0] data;
  } arf_sample_type;
endpackage : arf_pkg

//--- rtl/arf_accum.sv
`timescale 1ns/10ps
// one channel averager: sums groups of 2^(depth+1) samples, emits the mean
module arf_accum #(
  parameter int DW = 18
) (
  input  wire logic                    clock_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    avg_en_i,
  input  wire logic [1:0]              depth_i,
  input  wire arf_pkg::arf_sample_type in_i,
  output arf_pkg::arf_sample_type      out_o
);
  logic [DW+3:0]           sum_q, sum_d;
  logic [3:0]              cnt_q, cnt_d;
  arf_pkg::arf_sample_type out_q, out_d;
  logic [3:0]              last;
  logic [DW+3:0]           total;

  always_comb begin
    sum_d = sum_q;
    cnt_d = cnt_q;
    out_d = out_q;
    out_d.valid = 1'b0;
    last  = 4'((32'd2 << depth_i) - 32'd1);
    total = sum_q + {4'h0, in_i.data};
    if (!avg_en_i) begin
      sum_d = '0;
      cnt_d = '0;
      out_d = in_i;
    end else if (in_i.valid) begin
      if (cnt_q >= last) begin
        sum_d = '0;
        cnt_d = '0;
        out_d.valid = 1'b1;
        // shift widened to 3 bits so depth code 3 divides by 16 instead of wrapping to 0
        out_d.data  = DW'(total >> (3'(depth_i) + 3'd1));
      end else begin
        sum_d = total;
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sum_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
    end else begin
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign out_o = out_q;
endmodule : arf_accum

//--- rtl/arf_top.sv
`timescale 1ns/10ps
`include "arf_params.svh"
// Operation
// - format bit picks straight binary or two's complement
// - global gain calibration enable, resets off
// - averaging enable bit, off after reset
// - depth code 0..3 averages 2,4,8,16
module arf_top #(
  parameter int DW = 18
) (
  input  wire logic                    clock_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [15:0]             reg_wdata_i,
  output logic [15:0]                  reg_rdata_o,
  input  wire arf_pkg::arf_sample_type sample_a_i,
  input  wire arf_pkg::arf_sample_type sample_b_i,
  output arf_pkg::arf_sample_type      result_a_o,
  output arf_pkg::arf_sample_type      result_b_o,
  output logic                         gain_cal_global_enable_o,
  output logic [3:0]                   lane_cfg_o
);
  logic [15:0]             fmt_q, fmt_d;
  logic [15:0]             lane_q, lane_d;
  logic [7:0]              bank_q, bank_d;
  logic [15:0]             rdata_q, rdata_d;
  logic                    bank1;
  arf_pkg::arf_cfg_type    cfg;
  arf_pkg::arf_sample_type avg_out [2];
  arf_pkg::arf_sample_type res_q [2];
  arf_pkg::arf_sample_type res_d [2];
  arf_pkg::arf_sample_type raw_in [2];

  assign raw_in[0] = sample_a_i;
  assign raw_in[1] = sample_b_i;
  // bank 1 registers only answer once the selector points at bank 1
  assign bank1 = (bank_q == `ARF_BANK1_CODE);

  always_comb begin
    cfg.format_twos            = fmt_q[`ARF_BIT_FORMAT];
    cfg.gain_cal_global_enable = fmt_q[`ARF_BIT_GAIN_CAL];
    cfg.averaging_enable       = fmt_q[`ARF_BIT_AVG_EN];
    cfg.averaging_depth        = fmt_q[`ARF_DEPTH_MSB:`ARF_DEPTH_LSB];
  end

  always_comb begin
    fmt_d   = fmt_q;
    lane_d  = lane_q;
    bank_d  = bank_q;
    rdata_d = rdata_q;
    if (reg_wr_i) begin
      if (reg_addr_i == `ARF_ADDR_BANK_SEL) begin
        bank_d = reg_wdata_i[7:0];
      end else if (bank1 && reg_addr_i == `ARF_ADDR_FMT_AVG) begin
        // reserved bits stored as written; host keeps them at reset value
        fmt_d = reg_wdata_i;
      end else if (bank1 && reg_addr_i == `ARF_ADDR_LANE_CFG) begin
        lane_d = reg_wdata_i & `ARF_LANE_CFG_MASK;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `ARF_ADDR_BANK_SEL) begin
        rdata_d = {8'h00, bank_q};
      end else if (bank1 && reg_addr_i == `ARF_ADDR_FMT_AVG) begin
        rdata_d = fmt_q;
      end else if (bank1 && reg_addr_i == `ARF_ADDR_LANE_CFG) begin
        rdata_d = lane_q;
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fmt_q   <= `ARF_FMT_AVG_RESET;
      lane_q  <= `ARF_LANE_CFG_RESET;
      bank_q  <= `ARF_BANK_SEL_RESET;
      rdata_q <= 16'h0000;
    end else begin
      fmt_q   <= fmt_d;
      lane_q  <= lane_d;
      bank_q  <= bank_d;
      rdata_q <= rdata_d;
    end
  end

  // depth codes above 3 are treated as their low two bits
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    arf_accum #(
      .DW (DW)
    ) u_accum (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .avg_en_i (cfg.averaging_enable),
      .depth_i  (cfg.averaging_depth[1:0]),
      .in_i     (raw_in[ch]),
      .out_o    (avg_out[ch])
    );

    // averaging is done in straight binary; coding applied last
    always_comb begin
      res_d[ch]      = avg_out[ch];
      res_d[ch].data = cfg.format_twos ? (avg_out[ch].data ^ {1'b1, {(DW-1){1'b0}}})
                                       : avg_out[ch].data;
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        res_q[ch] <= '0;
      end else begin
        res_q[ch] <= res_d[ch];
      end
    end
  end

  logic gcal_q;
  logic gcal_d;
  logic [3:0] lane_out_q;
  logic [3:0] lane_out_d;

  always_comb begin
    gcal_d     = cfg.gain_cal_global_enable;
    lane_out_d = lane_q[3:0];
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gcal_q     <= 1'b0;
      lane_out_q <= 4'(`ARF_LANE_CFG_RESET);
    end else begin
      gcal_q     <= gcal_d;
      lane_out_q <= lane_out_d;
    end
  end

  assign reg_rdata_o              = rdata_q;
  assign result_a_o               = res_q[0];
  assign result_b_o               = res_q[1];
  assign gain_cal_global_enable_o = gcal_q;
  assign lane_cfg_o               = lane_out_q;
endmodule : arf_top

//--- testbench/arf_top_props.sv
`timescale 1ns/10ps
module arf_top_props (
  input wire logic                    clock_i,
  input wire logic                    arst_n_i,
  input wire logic                    reg_wr_i,
  input wire logic [7:0]              reg_addr_i,
  input wire logic [15:0]             reg_wdata_i,
  input wire arf_pkg::arf_sample_type sample_a_i,
  input wire arf_pkg::arf_sample_type result_a_o,
  input wire logic                    gain_cal_global_enable_o
);
  logic [15:0] cf_q, cf_d;
  logic [3:0]  ct_q, ct_d, last;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // code 3 wraps to zero, so last is 15
  assign last = (4'h2 << cf_q[3:2]) - 4'h1;
  always_comb begin
    // bank not tracked: the bench selects bank 1 before any write
    cf_d = (reg_wr_i && reg_addr_i == 8'h0D) ? reg_wdata_i : cf_q;
    ct_d = (sample_a_i.valid && ct_q != last) ? ct_q + 4'h1 : 4'h0;
    if (!sample_a_i.valid && cf_q[6]) ct_d = ct_q;
  end
  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i) {cf_q, ct_q} <= {16'h2002, 4'h0};
    else {cf_q, ct_q} <= {cf_d, ct_d & {4{cf_q[6]}}};
  raw_format_a: assert property (!cf_q[6] && sample_a_i.valid |-> ##2 result_a_o.valid &&
    result_a_o.data == ($past(sample_a_i.data, 2) ^ {cf_q[13], 17'h0})) else $error("raw word wrong");
  gain_follow_a: assert property (gain_cal_global_enable_o == $past(cf_q[7]))
    else $error("gain enable wrong");
  result_cause_a: assert property (result_a_o.valid |-> $past(sample_a_i.valid, 2))
    else $error("result without sample");
  group_hold_a: assert property (cf_q[6] && sample_a_i.valid && ct_q != last |-> ##2 !result_a_o.valid)
    else $error("early mean word");
  group_end_a: assert property (cf_q[6] && sample_a_i.valid && ct_q == last |-> ##2 result_a_o.valid)
    else $error("mean word missing");
  avg_out_c: cover property (cf_q[6] && result_a_o.valid);
  raw_out_c: cover property (!cf_q[6] && result_a_o.valid);
  gain_on_c: cover property (gain_cal_global_enable_o);
endmodule : arf_top_props
bind arf_top arf_top_props u_arf_top_props (.*);

//--- testbench/arf_host.sv
`timescale 1ns/10ps
// host capture: counts words, keeps the last
module arf_host (
  input  wire logic                    clock_i,
  input  wire logic                    arst_n_i,
  input  wire arf_pkg::arf_sample_type res_i,
  output logic [7:0]                   cnt_o,
  output logic [17:0]                  last_o
);
  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i) {cnt_o, last_o} <= '0;
    else if (res_i.valid) {cnt_o, last_o} <= {cnt_o + 8'h01, res_i.data};
endmodule : arf_host

//--- testbench/arf_top_bench.sv
`timescale 1ns/10ps
module arf_top_bench;
  logic clock_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, gain_cal_global_enable_o;
  logic [7:0] reg_addr_i = 0, ca, cb;
  logic [15:0] reg_wdata_i = 0, reg_rdata_o;
  logic [3:0] lane_cfg_o;
  logic [17:0] la, lb, va, vb;
  logic [21:0] sa, sb;
  arf_pkg::arf_sample_type sample_a_i = '0, sample_b_i = '0, result_a_o, result_b_o;
  int n_mismatch = 0, n_checks = 0, nr = 0;
  always #20 clock_i = ~clock_i;
  arf_top u_arf_top (.*);
  arf_host u_arf_host_a (.clock_i, .arst_n_i, .res_i(result_a_o), .cnt_o(ca), .last_o(la));
  arf_host u_arf_host_b (.clock_i, .arst_n_i, .res_i(result_b_o), .cnt_o(cb), .last_o(lb));
  task automatic chk(input string nm, input logic [17:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clock_i) reg_rd_i <= 1'b0;
    @(posedge clock_i) #1 chk("rdata", 18'(e), 18'(reg_rdata_o));
  endtask : rd
  function automatic logic [17:0] fmt(input logic [21:0] s, input int d, t);
    return 18'(s >> (d + 1)) ^ {t[0], 17'h0};
  endfunction : fmt
  // d of -1 is a single raw word
  task automatic grp(input int d, t);
    {sa, sb} = '0;
    for (int i = 0; i < (1 << (d + 1)); i++) begin
      va = 18'($urandom);
      vb = i[0] ? 18'h3FFFF : 18'($urandom);
      {sa, sb} = {sa + 22'(va), sb + 22'(vb)};
      @(posedge clock_i) {sample_a_i, sample_b_i} <= {1'b1, va, 1'b1, vb};
      @(posedge clock_i) {sample_a_i.valid, sample_b_i.valid} <= 2'b00;
    end
    repeat (4) @(posedge clock_i);
    nr++;
    chk("word_a", fmt(sa, d, t), la);
    chk("word_b", fmt(sb, d, t), lb);
    chk("count", 18'(nr), 18'(ca));
  endtask : grp
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(32'hD0412637));
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(8'h0D, 16'h0000);
    wr(8'h03, 16'h0002);
    rd(8'h0D, 16'h2002);
    rd(8'h12, 16'h0002);
    rd(8'h40, 16'h0000);
    chk("gain", 18'h0, 18'(gain_cal_global_enable_o));
    for (int t = 0; t < 2; t++) begin
      for (int d = 0; d < 4; d++) begin
        wr(8'h0D, 16'(32'h2 | t << 13));
        grp(-1, t);
        wr(8'h0D, 16'(32'h42 | d << 2 | t << 13));
        grp(d, t);
      end
    end
    // depth code 4 keeps only its low two bits, so it averages pairs
    wr(8'h0D, 16'h0052);
    grp(0, 0);
    wr(8'h0D, 16'h2082);
    // the enable output is registered once more after the register itself
    @(posedge clock_i) #1 chk("gain", 18'h1, 18'(gain_cal_global_enable_o));
    wr(8'h12, 16'hFFFF);
    rd(8'h12, 16'h000F);
    chk("lane", 18'hF, 18'(lane_cfg_o));
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    final_report;
  end
endmodule : arf_top_bench
